/* File: pdc_pkg.sv */
// pdc_pkg: constants, state codes and carriers for the divider config slave.
// assumes: shared by the design file and the testbench; no other users.
package pdc_pkg;
    localparam logic [6:0] PDC_DEV_ADDR = 7'h65;
    localparam logic [2:0] PDC_DUMMY_BYTES = 3'h2;
    localparam logic [2:0] PDC_LAST_BYTE = 3'h4;
    localparam logic [2:0] PDC_EXTRA_BYTE = 3'h5;
    localparam logic [3:0] PDC_ACK_SLOT = 4'h8;
    localparam logic [3:0] PDC_MSB_POS = 4'h7;
    localparam int PDC_BYPASS_POS = 7;
    localparam int PDC_SERIAL_POS = 6;
    localparam logic [1:0] PDC_IDX_CTRL = 2'h0;
    localparam logic [1:0] PDC_IDX_FB = 2'h1;
    localparam logic [1:0] PDC_IDX_SPARE = 2'h2;
    localparam logic [7:0] PDC_CTRL_RESET = 8'h00;
    localparam logic [7:0] PDC_FB_RESET = 8'h00;
    localparam logic [7:0] PDC_SPARE_RESET = 8'h00;
    localparam logic [9:0] PDC_FB_OFFSET = 10'h003;
    localparam logic [6:0] PDC_REF_OFFSET = 7'h02;
    localparam logic [6:0] PDC_REF_BYPASS = 7'h01;
    localparam logic [9:0] PDC_STRAP_MULT_LOW = 10'h010;
    localparam logic [9:0] PDC_STRAP_MULT_HIGH = 10'h008;
    localparam logic [6:0] PDC_STRAP_REF = 7'h01;
    localparam logic [7:0] PDC_DUMMY_READ = 8'h00;
    localparam logic [7:0] PDC_EXTRA_READ = 8'hFF;
    localparam int PDC_FREQ_W = 24;

    typedef enum logic [3:0] {
        PDC_IDLE  = 4'b0001,
        PDC_ADDR  = 4'b0010,
        PDC_WRITE = 4'b0100,
        PDC_READ  = 4'b1000
    } pdc_link_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] fb;
        logic [7:0] spare;
    } pdc_cfg_t;

    typedef struct packed {
        pdc_link_state_t state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [2:0] byteIdx;
        logic startAck;
        logic stopAck;
        logic wrTgl;
        logic [1:0] wrIdx;
        logic [7:0] wrData;
    } pdc_link_t;

    typedef struct packed {
        pdc_cfg_t cfg;
        logic [2:0] wrSync;
        logic [1:0] selSync;
        logic [1:0] oeSync;
        logic [9:0] fbDiv;
        logic [6:0] refDiv;
        logic outEn;
        logic [PDC_FREQ_W-1:0] freq;
    } pdc_sys_t;
endpackage : pdc_pkg

/* File: pdc_divider_config.sv */
// pdc_divider_config: two-wire slave that loads PLL divider codes, plus the
// divider selection (serial codes or strap pin), bypass and output enable.
// assumes: serial clock arrives as its own clock; data pin is split into
// in/out/enable with an external pull-up; rst is synchronous to clk_sys.
`timescale 1ns/1ps

// Summary of operation
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock low
// - ack held low across the ninth clock
// - matching address is acknowledged
// - direction zero writes, one reads
// - slave acknowledges every written byte
// - own address is 1100101, msb first
// - two leading dummy bytes are discarded
// - three config bytes stored, extras ignored
// - ctrl bit6 selects serial codes, resets low
// - feedback (code+3)*2, reference code+2
// - ctrl bit7 forces reference divider one
// - strap low gives x16, high x8
// - output frequency is ref times P over Q
// - output enable pin gates the clock output
// - feedback code eight bits, reference six
// - reads return stored bytes on data line
module pdc_divider_config import pdc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic twoWireClockPin,
    input wire logic twoWireDataIn,
    output logic twoWireDataOut,
    output logic twoWireDataOe,
    input wire logic multSelectPin,
    input wire logic outputEnablePin,
    input wire logic [PDC_FREQ_W-1:0] refFreqKhz,
    output logic [9:0] feedbackDivider,
    output logic [6:0] referenceDivider,
    output logic serialDivisorsUsed,
    output logic refDividerBypass,
    output logic clockOutEnable,
    output logic [PDC_FREQ_W-1:0] synthFreqKhz,
    output pdc_cfg_t divCfg
);

    function automatic logic [7:0] readByte(input logic [2:0] idx, input pdc_cfg_t cfg);
        logic [7:0] b;
        b = PDC_EXTRA_READ;
        if (idx < PDC_DUMMY_BYTES) begin
            b = PDC_DUMMY_READ;
        end else if (idx == PDC_DUMMY_BYTES) begin
            b = cfg.ctrl;
        end else if (idx == PDC_DUMMY_BYTES + 3'h1) begin
            b = cfg.fb;
        end else if (idx == PDC_LAST_BYTE) begin
            b = cfg.spare;
        end
        return b;
    endfunction : readByte

    function automatic logic [9:0] fbEffective(input logic [7:0] code);
        return (10'(code) + PDC_FB_OFFSET) << 1;
    endfunction : fbEffective

    function automatic logic [6:0] refEffective(input logic [5:0] code);
        return 7'(code) + PDC_REF_OFFSET;
    endfunction : refEffective

    // link-side reset, synchronised to the serial clock; needs clock edges
    logic [1:0] linkRstSync_q;
    logic rstLink;
    always_ff @(posedge twoWireClockPin) begin
        linkRstSync_q <= {linkRstSync_q[0], rst};
    end
    assign rstLink = linkRstSync_q[1];

    // start/stop seen as data edges during clock high; toggles read raw on
    // the serial clock because the start/stop hold time precedes any edge
    logic startTgl_q;
    logic stopTgl_q;
    always_ff @(negedge twoWireDataIn or posedge rstLink) begin
        if (rstLink) begin
            startTgl_q <= 1'b0;
        end else if (twoWireClockPin) begin
            startTgl_q <= ~startTgl_q;
        end
    end
    always_ff @(posedge twoWireDataIn or posedge rstLink) begin
        if (rstLink) begin
            stopTgl_q <= 1'b0;
        end else if (twoWireClockPin) begin
            stopTgl_q <= ~stopTgl_q;
        end
    end

    pdc_link_t lk_q;
    pdc_link_t lk_d;
    pdc_sys_t sys_q;
    pdc_sys_t sys_d;
    logic startPend;
    logic stopPend;
    logic addrMatch;
    logic [7:0] curByte;
    logic curBit;
    logic driveLow_q;
    logic driveLow_d;

    assign startPend = lk_q.startAck != startTgl_q;
    assign stopPend = lk_q.stopAck != stopTgl_q;
    assign addrMatch = lk_q.shift[7:1] == PDC_DEV_ADDR;
    // config bytes change only after this link's own write, so they are
    // quasi-static when sampled here for a read
    assign curByte = readByte(lk_q.byteIdx, sys_q.cfg);
    assign curBit = curByte[3'(PDC_MSB_POS - lk_q.bitCnt)];

    // data sampled on the rising serial clock edge, stable while high
    always_comb begin
        lk_d = lk_q;
        if (startPend) begin
            lk_d.startAck = startTgl_q;
            lk_d.stopAck = stopTgl_q;
            lk_d.state = PDC_ADDR;
            lk_d.shift = {7'h00, twoWireDataIn};
            lk_d.bitCnt = 4'h1;
            lk_d.byteIdx = 3'h0;
        end else if (stopPend) begin
            lk_d.stopAck = stopTgl_q;
            lk_d.state = PDC_IDLE;
            lk_d.bitCnt = 4'h0;
        end else begin
            case (lk_q.state)
                PDC_ADDR: begin
                    if (lk_q.bitCnt != PDC_ACK_SLOT) begin
                        lk_d.shift = {lk_q.shift[6:0], twoWireDataIn};
                        lk_d.bitCnt = lk_q.bitCnt + 4'h1;
                    end else begin
                        lk_d.bitCnt = 4'h0;
                        if (!addrMatch) begin
                            lk_d.state = PDC_IDLE;
                        end else if (lk_q.shift[0]) begin
                            lk_d.state = PDC_READ;
                        end else begin
                            lk_d.state = PDC_WRITE;
                        end
                    end
                end
                PDC_WRITE: begin
                    if (lk_q.bitCnt != PDC_ACK_SLOT) begin
                        lk_d.shift = {lk_q.shift[6:0], twoWireDataIn};
                        lk_d.bitCnt = lk_q.bitCnt + 4'h1;
                    end else begin
                        lk_d.bitCnt = 4'h0;
                        if (lk_q.byteIdx >= PDC_DUMMY_BYTES && lk_q.byteIdx <= PDC_LAST_BYTE) begin
                            lk_d.wrTgl = ~lk_q.wrTgl;
                            lk_d.wrIdx = 2'(lk_q.byteIdx - PDC_DUMMY_BYTES);
                            lk_d.wrData = lk_q.shift;
                        end
                        if (lk_q.byteIdx != PDC_EXTRA_BYTE) begin
                            lk_d.byteIdx = lk_q.byteIdx + 3'h1;
                        end
                    end
                end
                PDC_READ: begin
                    if (lk_q.bitCnt != PDC_ACK_SLOT) begin
                        lk_d.bitCnt = lk_q.bitCnt + 4'h1;
                    end else if (twoWireDataIn) begin
                        lk_d.state = PDC_IDLE; // master declined further data
                        lk_d.bitCnt = 4'h0;
                    end else begin
                        lk_d.bitCnt = 4'h0;
                        if (lk_q.byteIdx != PDC_EXTRA_BYTE) begin
                            lk_d.byteIdx = lk_q.byteIdx + 3'h1;
                        end
                    end
                end
                default: begin
                    lk_d.state = PDC_IDLE;
                    lk_d.bitCnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge twoWireClockPin) begin
        if (rstLink) begin
            lk_q <= '0;
            lk_q.state <= PDC_IDLE;
        end else begin
            lk_q <= lk_d;
        end
    end

    // drive decisions land on the falling edge, so the line is settled
    // before the next rising edge and held through it
    always_comb begin
        driveLow_d = 1'b0;
        if (!startPend && !stopPend) begin
            if (lk_q.state == PDC_ADDR && lk_q.bitCnt == PDC_ACK_SLOT) begin
                driveLow_d = addrMatch;
            end else if (lk_q.state == PDC_WRITE && lk_q.bitCnt == PDC_ACK_SLOT) begin
                driveLow_d = 1'b1;
            end else if (lk_q.state == PDC_READ && lk_q.bitCnt != PDC_ACK_SLOT) begin
                driveLow_d = !curBit;
            end
        end
    end

    always_ff @(negedge twoWireClockPin) begin
        if (rstLink) begin
            driveLow_q <= 1'b0;
        end else begin
            driveLow_q <= driveLow_d;
        end
    end

    assign twoWireDataOut = 1'b0;
    assign twoWireDataOe = driveLow_q;

    // system side: write toggle crossing, pin synchronisers, divider select
    always_comb begin
        sys_d = sys_q;
        sys_d.wrSync = {sys_q.wrSync[1:0], lk_q.wrTgl};
        sys_d.selSync = {sys_q.selSync[0], multSelectPin};
        sys_d.oeSync = {sys_q.oeSync[0], outputEnablePin};
        // write data is held for a whole byte time, far beyond the sync delay
        if (sys_q.wrSync[2] != sys_q.wrSync[1]) begin
            if (lk_q.wrIdx == PDC_IDX_CTRL) begin
                sys_d.cfg.ctrl = lk_q.wrData;
            end else if (lk_q.wrIdx == PDC_IDX_FB) begin
                sys_d.cfg.fb = lk_q.wrData;
            end else if (lk_q.wrIdx == PDC_IDX_SPARE) begin
                sys_d.cfg.spare = lk_q.wrData;
            end
        end
        sys_d.outEn = sys_q.oeSync[1];
        if (sys_q.cfg.ctrl[PDC_SERIAL_POS]) begin
            sys_d.fbDiv = fbEffective(sys_q.cfg.fb);
            if (sys_q.cfg.ctrl[PDC_BYPASS_POS]) begin
                sys_d.refDiv = PDC_REF_BYPASS;
            end else begin
                sys_d.refDiv = refEffective(sys_q.cfg.ctrl[5:0]);
            end
        end else begin
            // pin pull-up lives in the pad; unconnected reads as high
            sys_d.fbDiv = sys_q.selSync[1] ? PDC_STRAP_MULT_HIGH : PDC_STRAP_MULT_LOW;
            sys_d.refDiv = PDC_STRAP_REF;
        end
        // divider by a live value is slow; result lags the dividers by a cycle
        sys_d.freq = PDC_FREQ_W'((34'(refFreqKhz) * 34'(sys_q.fbDiv)) / 34'(sys_q.refDiv));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_q <= '0;
            sys_q.cfg <= '{PDC_CTRL_RESET, PDC_FB_RESET, PDC_SPARE_RESET};
            sys_q.fbDiv <= PDC_STRAP_MULT_HIGH;
            sys_q.refDiv <= PDC_STRAP_REF;
        end else begin
            sys_q <= sys_d;
        end
    end

    assign feedbackDivider = sys_q.fbDiv;
    assign referenceDivider = sys_q.refDiv;
    assign serialDivisorsUsed = sys_q.cfg.ctrl[PDC_SERIAL_POS];
    assign refDividerBypass = sys_q.cfg.ctrl[PDC_BYPASS_POS];
    assign clockOutEnable = sys_q.outEn;
    assign synthFreqKhz = sys_q.freq;
    assign divCfg = sys_q.cfg;

    logic wrPulse;
    assign wrPulse = sys_q.wrSync[2] != sys_q.wrSync[1];

    addr_ack_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_ADDR && lk_q.bitCnt == PDC_ACK_SLOT && addrMatch
            && !startPend && !stopPend) |-> driveLow_q)
        else $error("matching address not acknowledged");

    foreign_addr_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_ADDR && lk_q.bitCnt == PDC_ACK_SLOT && !addrMatch)
            |-> !driveLow_q ##1 lk_q.state == PDC_IDLE)
        else $error("foreign address acknowledged or kept");

    write_ack_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_WRITE && lk_q.bitCnt == PDC_ACK_SLOT
            && !startPend && !stopPend) |-> driveLow_q)
        else $error("written byte not acknowledged");

    cfg_store_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_WRITE && lk_q.bitCnt == PDC_ACK_SLOT && !startPend && !stopPend
            && lk_q.byteIdx >= PDC_DUMMY_BYTES && lk_q.byteIdx <= PDC_LAST_BYTE)
            |=> lk_q.wrTgl != $past(lk_q.wrTgl) && lk_q.wrData == $past(lk_q.shift))
        else $error("config byte not forwarded");

    dummy_skip_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_WRITE && lk_q.bitCnt == PDC_ACK_SLOT
            && (lk_q.byteIdx < PDC_DUMMY_BYTES || lk_q.byteIdx == PDC_EXTRA_BYTE))
            |=> $stable(lk_q.wrTgl))
        else $error("dummy or extra byte stored");

    read_drive_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        (lk_q.state == PDC_READ && lk_q.bitCnt != PDC_ACK_SLOT && !startPend && !stopPend)
            |-> driveLow_q == !curBit)
        else $error("read bit driven wrongly");

    ctrl_load_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (wrPulse && lk_q.wrIdx == PDC_IDX_CTRL) |=> sys_q.cfg.ctrl == $past(lk_q.wrData))
        else $error("control byte not loaded");

    fb_serial_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (sys_q.cfg.ctrl[PDC_SERIAL_POS] && !sys_q.cfg.ctrl[PDC_BYPASS_POS])
            ##1 $stable(sys_q.cfg) |->
            sys_q.fbDiv == (10'(sys_q.cfg.fb) + 10'h003) * 10'h002
            && sys_q.refDiv == 7'(sys_q.cfg.ctrl[5:0]) + 7'h02)
        else $error("serial dividers wrong");

    bypass_one_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (sys_q.cfg.ctrl[PDC_SERIAL_POS] && sys_q.cfg.ctrl[PDC_BYPASS_POS])
            |=> sys_q.refDiv == 7'h01)
        else $error("bypass did not force one");

    strap_mult_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!sys_q.cfg.ctrl[PDC_SERIAL_POS] && !sys_q.selSync[1])
            |=> sys_q.fbDiv == 10'h010 && sys_q.refDiv == 7'h01)
        else $error("strap low not x16");

    oe_follow_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(sys_q.oeSync[1]) |=> clockOutEnable)
        else $error("output enable not followed");

    start_addr_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        startPend |=> lk_q.state == PDC_ADDR && lk_q.bitCnt == 4'h1)
        else $error("start did not open address phase");

    idle_release_a: assert property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        lk_q.state == PDC_IDLE |-> !driveLow_q)
        else $error("data line pulled while idle");

    fb_load_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (wrPulse && lk_q.wrIdx == PDC_IDX_FB) |=> sys_q.cfg.fb == $past(lk_q.wrData))
        else $error("feedback byte not loaded");

    addr_ack_c: cover property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        lk_q.state == PDC_ADDR ##1 lk_q.state == PDC_WRITE);

    read_seen_c: cover property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        lk_q.state == PDC_READ && lk_q.byteIdx == PDC_LAST_BYTE);

    ctrl_serial_c: cover property (
        @(posedge clk_sys) disable iff (rst)
        $rose(sys_q.cfg.ctrl[PDC_SERIAL_POS]));

    // master ends a read by declining the next byte
    read_nack_c: cover property (
        @(posedge twoWireClockPin) disable iff (rstLink)
        lk_q.state == PDC_READ ##1 lk_q.state == PDC_IDLE);

    strap_low_c: cover property (
        @(posedge clk_sys) disable iff (rst)
        !sys_q.cfg.ctrl[PDC_SERIAL_POS] && !sys_q.selSync[1]);

endmodule : pdc_divider_config

/* File: pdc_bus_master.sv */
// pdc_bus_master: behavioural two-wire bus master for the divider config slave.
// assumes: the bench resolves the data line from both enables and a pull-up.
`timescale 1ns/1ps
module pdc_bus_master (
    output logic sclk,
    output logic sdaOe,
    input wire logic sda
);
    localparam int QTR = 20;
    // clock idles high and stands still outside frames
    initial begin
        sclk = 1'b1;
        sdaOe = 1'b0;
    end
    // free pulses only so the slave's link side sees reset
    task automatic pulses(input int n);
        repeat (n) begin
            sclk = 1'b0;
            #(2*QTR);
            sclk = 1'b1;
            #(2*QTR);
        end
    endtask : pulses
    // also serves as repeated start when entered with the clock low
    task automatic start();
        sdaOe = 1'b0;
        #QTR sclk = 1'b1;
        #QTR sdaOe = 1'b1;
        #QTR sclk = 1'b0;
        #QTR;
    endtask : start
    task automatic bitXfer(input logic b, output logic r);
        sdaOe = ~b;
        #QTR sclk = 1'b1;
        #QTR r = sda;
        #QTR sclk = 1'b0;
        #QTR;
    endtask : bitXfer
    // ackOut is what we place in the ninth slot: 1 releases, 0 acknowledges
    task automatic byteXfer(input logic [7:0] wr, input logic ackOut,
                            output logic [7:0] rd, output logic ninth);
        for (int i = 7; i >= 0; i--) begin
            bitXfer(wr[i], rd[i]);
        end
        bitXfer(ackOut, ninth);
    endtask : byteXfer
    task automatic stop();
        sdaOe = 1'b1;
        #QTR sclk = 1'b1;
        #QTR sdaOe = 1'b0;
        #(2*QTR);
    endtask : stop
endmodule : pdc_bus_master

/* File: pdc_divider_config_tb.sv */
// pdc_divider_config_tb: random and corner tests of the divider config slave.
// assumes: pdc_bus_master stands on the bus; data line has a pull-up here.
`timescale 1ns/1ps
module pdc_divider_config_tb import pdc_pkg::*;;
    localparam logic [6:0] OWN_ADDR = 7'b1100101;
    logic clk_sys, rst, sclk, mstOe, devOut, devOe, sdaLine;
    logic multSelectPin, outputEnablePin, serialDivisorsUsed, refDividerBypass, clockOutEnable;
    logic [PDC_FREQ_W-1:0] refFreqKhz, synthFreqKhz;
    logic [9:0] feedbackDivider;
    logic [6:0] referenceDivider;
    pdc_cfg_t divCfg, cfg;
    int err_count, cmp_count;
    // open-drain wire: any enabled party pulls low, otherwise pull-up
    assign sdaLine = (devOe ? devOut : 1'b1) & ~mstOe;
    pdc_divider_config u_pdc_divider_config (
        .clk_sys(clk_sys), .rst(rst), .twoWireClockPin(sclk),
        .twoWireDataIn(sdaLine), .twoWireDataOut(devOut), .twoWireDataOe(devOe),
        .multSelectPin(multSelectPin), .outputEnablePin(outputEnablePin),
        .refFreqKhz(refFreqKhz), .feedbackDivider(feedbackDivider),
        .referenceDivider(referenceDivider), .serialDivisorsUsed(serialDivisorsUsed),
        .refDividerBypass(refDividerBypass), .clockOutEnable(clockOutEnable),
        .synthFreqKhz(synthFreqKhz), .divCfg(divCfg));
    pdc_bus_master u_pdc_bus_master (.sclk(sclk), .sdaOe(mstOe), .sda(sdaLine));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : check
    function automatic logic [9:0] expP(input pdc_cfg_t c, input logic pin);
        if (c.ctrl[6]) return ({2'b00, c.fb} + 10'h003) * 10'h002;
        return pin ? 10'h008 : 10'h010;
    endfunction : expP
    function automatic logic [6:0] expQ(input pdc_cfg_t c);
        if (!c.ctrl[6] || c.ctrl[7]) return 7'h01;
        return {1'b0, c.ctrl[5:0]} + 7'h02;
    endfunction : expQ
    task automatic setPins(input logic sel, input logic oe, input logic [23:0] refK);
        @(negedge clk_sys);
        multSelectPin = sel;
        outputEnablePin = oe;
        refFreqKhz = refK;
    endtask : setPins
    // sync stages plus divider and frequency registers all settle well inside 10 cycles
    task automatic checkOut(input pdc_cfg_t c);
        logic [9:0] p;
        logic [6:0] q;
        repeat (10) @(negedge clk_sys);
        p = expP(c, multSelectPin);
        q = expQ(c);
        check(divCfg, c, "stored bytes");
        check(serialDivisorsUsed, c.ctrl[6], "serial select");
        check(refDividerBypass, c.ctrl[7], "bypass");
        check(feedbackDivider, p, "feedback divider");
        check(referenceDivider, q, "reference divider");
        check(synthFreqKhz, 24'((64'(refFreqKhz) * p) / q), "frequency");
        check(clockOutEnable, outputEnablePin, "output enable");
    endtask : checkOut
    // leaves the clock low so the caller may stop or restart
    task automatic writeCfg(input logic [6:0] addr, input pdc_cfg_t c, input logic expAck);
        logic [7:0] bytes [6];
        logic [7:0] rd;
        logic ninth;
        bytes = '{8'($urandom), 8'($urandom), c.ctrl, c.fb, c.spare, 8'($urandom)};
        u_pdc_bus_master.start();
        u_pdc_bus_master.byteXfer({addr, 1'b0}, 1'b1, rd, ninth);
        check(ninth, !expAck, "address ack");
        if (expAck) begin
            foreach (bytes[i]) begin
                u_pdc_bus_master.byteXfer(bytes[i], 1'b1, rd, ninth);
                check(ninth, 1'b0, "write byte ack");
            end
        end
    endtask : writeCfg
    task automatic readCfg(input pdc_cfg_t c);
        logic [7:0] expB [6];
        logic [7:0] rd;
        logic ninth;
        expB = '{8'h00, 8'h00, c.ctrl, c.fb, c.spare, 8'hFF};
        u_pdc_bus_master.start();
        u_pdc_bus_master.byteXfer({OWN_ADDR, 1'b1}, 1'b1, rd, ninth);
        check(ninth, 1'b0, "read address ack");
        foreach (expB[i]) begin
            u_pdc_bus_master.byteXfer(8'hFF, i == 5, rd, ninth);
            check(rd, expB[i], "read byte");
        end
        u_pdc_bus_master.stop();
    endtask : readCfg
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        #400000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
    initial begin
        pdc_cfg_t c;
        logic [6:0] badAddr [3];
        err_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        multSelectPin = 1'b1;
        outputEnablePin = 1'b0;
        refFreqKhz = 24'h001000;
        cfg = '0;
        badAddr = '{7'h64, 7'h25, 7'h53};
        void'($urandom(32'h9E61));
        // link side resets only while the serial clock runs
        fork
            repeat (16) @(posedge clk_sys);
            u_pdc_bus_master.pulses(5);
        join
        @(negedge clk_sys);
        rst = 1'b0;
        u_pdc_bus_master.pulses(3);
        checkOut(cfg);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            setPins(k[0], k[1], 24'($urandom_range(16383, 1)));
            checkOut(cfg);
        end
        $display("test strap done");
        // two one-bit-off addresses and the bit-reversed own address must all be ignored
        foreach (badAddr[i]) begin
            writeCfg(badAddr[i], 24'($urandom), 1'b0);
            u_pdc_bus_master.stop();
            checkOut(cfg);
        end
        $display("test address done");
        for (int n = 0; n < 8; n++) begin
            c = (n == 0) ? {8'hC0, 8'hFF, 8'hA5} : (n == 1) ? {8'h7F, 8'h00, 8'h5A} : 24'($urandom);
            setPins(1'($urandom), 1'($urandom), 24'($urandom_range(16383, 1)));
            writeCfg(OWN_ADDR, c, 1'b1);
            if (!n[0]) begin
                u_pdc_bus_master.stop();
            end
            readCfg(c);
            checkOut(c);
        end
        $display("test config done");
        results();
    end
endmodule : pdc_divider_config_tb
